/* src/ssh_pkg.sv */
// Constants and types shared by the serial host port and its testbench
package ssh_pkg;
  localparam int          ADDR_W       = 16;
  localparam int          LEN_W        = 15;
  localparam int          HDR_W        = 32;
  localparam int          BYTE_W       = 8;
  localparam int          N_IRQ        = 4;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          WR_W         = ADDR_W + BYTE_W;
  // Header field positions within the 32-bit header shift word
  localparam int          HDR_ADDR_LSB = 16;
  localparam int          HDR_RW_BIT   = 15;
  localparam logic [4:0]  HDR_LAST     = 5'h1f;
  localparam logic [2:0]  BYTE_LAST    = 3'h7;
  localparam logic        RW_READ      = 1'h0;
  localparam logic        RW_WRITE     = 1'h1;
  // Interrupt source bit positions
  localparam int          IRQ_CONNECT  = 0;
  localparam int          IRQ_DISCON   = 1;
  localparam int          IRQ_TIMEOUT  = 2;
  localparam int          IRQ_WOL      = 3;
  // Addresses of the interrupt registers that release irq_n
  localparam logic [15:0] GLOBAL_IR_ADDR = 16'h0015;
  localparam logic [3:0]  SOCK_IR_PAGE   = 4'h4;
  localparam logic [7:0]  SOCK_IR_OFS    = 8'h02;
  localparam logic [2:0]  RST_CNT        = 3'h0;
  localparam logic [14:0] LEN_ONE        = 15'h0001;

  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_DATA, ST_DONE} ssh_state_t;
endpackage : ssh_pkg

/* src/ssh_fifo.sv */
// Parameterised valid/ready FIFO for write bytes leaving the port
`timescale 1ns/1ps
module ssh_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         ce,
  input  wire logic         s_valid,
  output logic              s_ready,
  input  wire logic [W-1:0] s_data,
  output logic              m_valid,
  input  wire logic         m_ready,
  output logic [W-1:0]      m_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0]   count_q;
  wire           push = s_valid && s_ready;
  wire           pop  = m_valid && m_ready;

  assign s_ready = (count_q != DEPTH[AW:0]);
  assign m_valid = (count_q != '0);
  assign m_data  = mem[rptr_q];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wptr_q  <= '0;
      rptr_q  <= '0;
      count_q <= '0;
    end else if (ce) begin
      if (push) begin
        mem[wptr_q] <= s_data;
        wptr_q      <= wptr_q + 1'b1;
      end
      if (pop)
        rptr_q <= rptr_q + 1'b1;
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end
endmodule : ssh_fifo

/* src/ssh_port.sv */
// Serial slave host port: frame decode, read/write paths and interrupt pin
`timescale 1ns/1ps
// Summary of operation
// - Slave only; host clocks every transfer
// - Clock modes 0 and 3 only
// - Either idle clock level accepted unchanged
// - Sample host data on rising clock
// - Drive reply data on falling clock
// - Chip select active low gates transfers
// - Events pull interrupt output low
// - Interrupt register writes release; sources maskable
// - Power-down input high blocks new frames
// - Header: 16-bit address, opcode, 15-bit length
// - Opcode zero reads, one writes
// - Opcode is MSB of third byte
// - Length one single, larger gives burst
module ssh_port
  import ssh_pkg::*;
#(
  parameter int FIFO_D = FIFO_DEPTH
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                ce,
  input  wire logic                sclk,
  input  wire logic                mosi,
  input  wire logic                slave_select_n,
  output logic                     miso,
  output logic                     miso_oe,
  output logic                     irq_n,
  input  wire logic                power_down_in,
  output logic                     low_power,
  input  wire logic [N_IRQ-1:0]    irq_event,
  input  wire logic [N_IRQ-1:0]    irq_mask,
  output logic                     rd_req,
  output logic [ADDR_W-1:0]        rd_addr,
  input  wire logic                rd_valid,
  input  wire logic [BYTE_W-1:0]   rd_data,
  output logic                     wr_valid,
  input  wire logic                wr_ready,
  output logic [ADDR_W-1:0]        wr_addr,
  output logic [BYTE_W-1:0]        wr_data,
  output logic                     wr_overflow
);
  function automatic logic [ADDR_W-1:0] next_addr(logic [ADDR_W-1:0] a);
    return a + 16'h0001;
  endfunction : next_addr

  // Pin synchronisers; stage 1 is read only by stage 2
  logic [2:0] sclk_sy_q;
  logic [2:0] ss_sy_q;
  logic [1:0] mosi_sy_q;
  logic [1:0] pd_sy_q;

  ssh_state_t          st_q;
  ssh_state_t          st_d;
  logic [4:0]          bit_cnt_q;
  logic [HDR_W-1:0]    shift_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [LEN_W-1:0]    len_q;
  logic                rw_q;
  logic [BYTE_W-1:0]   tx_q;
  logic [N_IRQ-1:0]    pend_q;
  logic                miso_q;
  logic                miso_oe_q;
  logic                irq_n_q;
  logic                rd_req_q;
  logic [ADDR_W-1:0]   rd_addr_q;
  logic                ovf_q;
  logic                fifo_ready;
  logic [WR_W-1:0]     fifo_out;

  // Only edges are used, so idle level of the clock does not matter
  wire sclk_rise = sclk_sy_q[1] && !sclk_sy_q[2];
  wire sclk_fall = !sclk_sy_q[1] && sclk_sy_q[2];
  wire selected  = !ss_sy_q[1];
  wire pd_on     = pd_sy_q[1];
  wire [HDR_W-1:0] shift_nx = {shift_q[HDR_W-2:0], mosi_sy_q[1]};
  wire hdr_end   = (st_q == ST_HDR) && sclk_rise && (bit_cnt_q == HDR_LAST);
  wire byte_end  = (st_q == ST_DATA) && sclk_rise
                   && (bit_cnt_q[2:0] == BYTE_LAST);
  wire hdr_rw    = shift_nx[HDR_RW_BIT];
  wire [LEN_W-1:0] hdr_len = shift_nx[LEN_W-1:0];
  wire wr_byte   = byte_end && (rw_q == RW_WRITE);
  wire last_byte = byte_end && (len_q == LEN_ONE);
  wire more_rd   = byte_end && (rw_q == RW_READ) && !last_byte;
  wire hdr_rd    = hdr_end && (hdr_rw == RW_READ) && (hdr_len != '0);
  wire ir_hit    = (addr_q == GLOBAL_IR_ADDR)
                   || (addr_q[15:12] == SOCK_IR_PAGE
                       && addr_q[7:0] == SOCK_IR_OFS);
  wire [N_IRQ-1:0] ir_clr = (wr_byte && ir_hit) ? shift_nx[N_IRQ-1:0]
                                                : '0;
  // Set wins over a clear landing in the same cycle
  wire [N_IRQ-1:0] pend_d = (pend_q & ~ir_clr) | irq_event;
  wire tx_mode = (st_q == ST_DATA) && (rw_q == RW_READ);

  // Frame sequencing; the device never starts a transfer itself
  always_comb begin
    st_d = st_q;
    if (!selected)
      st_d = ST_IDLE;
    else
      unique case (st_q)
        ST_IDLE: if (!pd_on) st_d = ST_HDR;
        ST_HDR:  if (hdr_end)
                   st_d = (hdr_len == '0) ? ST_DONE : ST_DATA;
        ST_DATA: if (last_byte) st_d = ST_DONE;
        ST_DONE: st_d = ST_DONE;
      endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclk_sy_q <= '0;
      ss_sy_q   <= 3'h7;
      mosi_sy_q <= '0;
      pd_sy_q   <= '0;
    end else if (ce) begin
      sclk_sy_q <= {sclk_sy_q[1:0], sclk};
      ss_sy_q   <= {ss_sy_q[1:0], slave_select_n};
      mosi_sy_q <= {mosi_sy_q[0], mosi};
      pd_sy_q   <= {pd_sy_q[0], power_down_in};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q      <= ST_IDLE;
      bit_cnt_q <= '0;
      shift_q   <= '0;
      addr_q    <= '0;
      len_q     <= '0;
      rw_q      <= RW_READ;
    end else if (ce) begin
      st_q <= st_d;
      if (st_q == ST_IDLE)
        bit_cnt_q <= '0;
      else if (hdr_end)
        bit_cnt_q <= '0;
      else if (sclk_rise)
        bit_cnt_q <= bit_cnt_q + 5'h01;
      if (sclk_rise && st_q != ST_IDLE)
        shift_q <= shift_nx;
      if (hdr_end) begin
        addr_q <= shift_nx[HDR_W-1:HDR_ADDR_LSB];
        rw_q   <= hdr_rw;
        len_q  <= hdr_len;
      end else if (byte_end) begin
        addr_q <= next_addr(addr_q);
        len_q  <= len_q - LEN_ONE;
      end
    end
  end

  // Reply path: byte fetched ahead, shifted out on falling edges
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_q      <= '0;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
      rd_req_q  <= 1'b0;
      rd_addr_q <= '0;
    end else if (ce) begin
      miso_oe_q <= selected && (st_q != ST_IDLE);
      rd_req_q  <= hdr_rd || more_rd;
      if (hdr_rd)
        rd_addr_q <= shift_nx[HDR_W-1:HDR_ADDR_LSB];
      else if (more_rd)
        rd_addr_q <= next_addr(addr_q);
      if (rd_valid)
        tx_q <= rd_data;
      else if (tx_mode && sclk_fall)
        tx_q <= {tx_q[BYTE_W-2:0], 1'b0};
      if (!selected)
        miso_q <= 1'b0;
      else if (sclk_fall)
        miso_q <= tx_mode ? tx_q[BYTE_W-1] : 1'b0;
    end
  end

  // Interrupt pending bits, mask and write overflow
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pend_q  <= '0;
      irq_n_q <= 1'b1;
      ovf_q   <= 1'b0;
    end else if (ce) begin
      pend_q  <= pend_d;
      irq_n_q <= ~|(pend_d & irq_mask);
      // Set wins over the deselect clear in the same cycle
      if (wr_byte && !fifo_ready)
        ovf_q <= 1'b1;
      else if (!selected)
        ovf_q <= 1'b0;
    end
  end

  ssh_fifo #(.W(WR_W), .DEPTH(FIFO_D)) u_fifo (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .s_valid (wr_byte),
    .s_ready (fifo_ready),
    .s_data  ({addr_q, shift_nx[BYTE_W-1:0]}),
    .m_valid (wr_valid),
    .m_ready (wr_ready),
    .m_data  (fifo_out)
  );

  assign wr_addr     = fifo_out[WR_W-1:BYTE_W];
  assign wr_data     = fifo_out[BYTE_W-1:0];
  assign miso        = miso_q;
  assign miso_oe     = miso_oe_q;
  assign irq_n       = irq_n_q;
  assign rd_req      = rd_req_q;
  assign rd_addr     = rd_addr_q;
  assign wr_overflow = ovf_q;
  assign low_power   = pd_sy_q[1];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_hdr_done;
    ce && hdr_end;
  endsequence
  sequence s_rd_hdr;
    ce && hdr_rd;
  endsequence

  a_deselect_hiz: assert property (ce && !selected |=> !miso_oe_q)
    else $error("output enabled while deselected");
  a_event_irq: assert property (
    ce && |(irq_event & irq_mask) |=> !irq_n_q)
    else $error("unmasked event did not pull irq low");
  a_clear_release: assert property (
    ce && wr_byte && ir_hit && shift_nx[N_IRQ-1:0] == 4'hf
    && irq_event == '0 |=> pend_q == '0)
    else $error("interrupt register write did not clear");
  a_rise_sample: assert property (
    ce && sclk_rise && st_q == ST_HDR |=> shift_q[0] == $past(mosi_sy_q[1]))
    else $error("host bit not sampled on rising edge");
  a_fall_drive: assert property (
    ce && selected && sclk_fall && tx_mode
    |=> miso_q == $past(tx_q[BYTE_W-1]))
    else $error("reply bit not driven on falling edge");
  a_pd_blocks: assert property (
    ce && pd_on && st_q == ST_IDLE |=> st_q == ST_IDLE)
    else $error("frame started while powered down");
  a_hdr_addr: assert property (
    s_hdr_done |=> addr_q == $past(shift_nx[HDR_W-1:HDR_ADDR_LSB])
    && st_q != ST_HDR)
    else $error("header address not captured");
  a_read_req: assert property (s_rd_hdr |=> rd_req_q ##1 !rd_req_q)
    else $error("read header gave no single fetch pulse");
  a_burst_addr: assert property (
    ce && byte_end && selected |=> addr_q == next_addr($past(addr_q)))
    else $error("burst address did not advance");
  a_single_done: assert property (
    ce && last_byte && selected |=> st_q == ST_DONE)
    else $error("frame continued past its length");
endmodule : ssh_port

/* verification/ssh_host_model.sv */
// Host master model driving the serial link
`timescale 1ns/1ps
module ssh_host_model (
  input  wire logic clk,
  input  wire logic miso,
  input  wire logic miso_oe,
  output logic      sclk,
  output logic      mosi,
  output logic      slave_select_n
);
  logic m3_q;
  logic last_q = 1'b0;
  // No pull on the reply line: a released line reads as the inverse
  wire  line = miso_oe ? miso : ~last_q;
  always @(posedge clk) begin
    if (miso_oe) last_q <= miso;
  end
  initial begin
    m3_q = 1'b0;
    sclk = 1'b0;
    mosi = 1'b0;
    slave_select_n = 1'b1;
  end
  task automatic start(input logic m3);
    m3_q = m3;
    @(posedge clk) sclk <= m3;
    repeat (4) @(posedge clk);
    slave_select_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : start
  // One byte, MSB first; 8 clk per bit gives the 80 ns link period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk) sclk <= 1'b0;
      mosi <= tx[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      rx[i] = line;
      repeat (3) @(posedge clk);
    end
  endtask : xfer
  task automatic stop;
    @(posedge clk) sclk <= m3_q;
    mosi <= ~mosi;
    repeat (4) @(posedge clk);
    slave_select_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : stop
endmodule : ssh_host_model

/* verification/spi_slave_host_port_tb.sv */
// Self-checking bench for the serial host port
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("Error at %0t: value mismatch", $time); end end
module spi_slave_host_port_tb
  import ssh_pkg::*;
;
  logic        clk, reset_n, ce, sclk, mosi, slave_select_n, miso;
  logic        miso_oe, irq_n, power_down_in, low_power, rd_req;
  logic        rd_valid, wr_valid, wr_ready, wr_overflow, stall, ign;
  logic [3:0]  irq_event, irq_mask;
  logic [15:0] rd_addr, wr_addr;
  logic [7:0]  rd_data, wr_data;
  logic [31:0] seed = 32'd34;
  logic [23:0] exp_q[$];
  int          failures, tests_run;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ssh_port #(.FIFO_D(FIFO_DEPTH)) ssh_port_inst (.clk, .reset_n, .ce,
    .sclk, .mosi, .slave_select_n, .miso, .miso_oe, .irq_n,
    .power_down_in, .low_power, .irq_event, .irq_mask, .rd_req, .rd_addr,
    .rd_valid, .rd_data, .wr_valid, .wr_ready, .wr_addr, .wr_data,
    .wr_overflow);
  ssh_host_model ssh_host_model_inst (.clk, .miso, .miso_oe, .sclk, .mosi,
    .slave_select_n);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [7:0] rdb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : rdb
  // Memory side: answers fetches, drains writes with random stalls
  always @(posedge clk) begin
    seed <= xs(seed);
    rd_valid <= rd_req;
    rd_data <= rdb(rd_addr);
    wr_ready <= seed[0] & ~stall;
    if (wr_valid === 1'b1 && wr_ready === 1'b1 && !ign) begin
      `CHK({wr_addr, wr_data}, exp_q.pop_front())
    end
  end
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic frame(input logic m3, input logic [15:0] a,
      input logic rw, input logic [14:0] len, input int n,
      input logic [7:0] fix, input logic en);
    logic [7:0] rx, tx;
    ssh_host_model_inst.start(m3);
    ssh_host_model_inst.xfer(a[15:8], rx);
    ssh_host_model_inst.xfer(a[7:0], rx);
    ssh_host_model_inst.xfer({rw, len[14:8]}, rx);
    ssh_host_model_inst.xfer(len[7:0], rx);
    for (int i = 0; i < n; i++) begin
      tx = fix | seed[15:8];
      if (en && rw == RW_WRITE && i < len &&
          (!stall || exp_q.size() < FIFO_DEPTH))
        exp_q.push_back({a + 16'(i), tx});
      ssh_host_model_inst.xfer(tx, rx);
      if (en && rw == RW_READ && i < len)
        `CHK(rx, rdb(a + 16'(i)))
    end
    repeat (4) @(posedge clk);
  endtask : frame
  task automatic drain;
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 400) begin
      @(posedge clk);
      k++;
    end
    `CHK(exp_q.size(), 0)
  endtask : drain
  task automatic pulse(input int k);
    @(posedge clk) irq_event <= 4'h1 << k;
    @(posedge clk) irq_event <= 4'h0;
    repeat (2) @(posedge clk);
  endtask : pulse
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial begin
    {reset_n, power_down_in, stall, ign} = 4'h0;
    {irq_event, irq_mask} = 8'h0;
    ce = 1'b1;
    // Reset shortened; host waits before first access
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    `CHK({miso_oe, irq_n, wr_valid, wr_overflow}, 4'h4)
    repeat (6) @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      frame(m[0], seed[15:0], RW_READ, LEN_ONE, 1, 8'h0, 1'b1);
      ssh_host_model_inst.stop();
      frame(m[0], seed[15:0], RW_READ, 15'h3, 4, 8'h0, 1'b1);
      `CHK(miso_oe, 1'b1)
      ssh_host_model_inst.stop();
      `CHK(miso_oe, 1'b0)
      frame(m[0], seed[15:0], RW_WRITE, 15'h5, 5, 8'h0, 1'b1);
      ssh_host_model_inst.stop();
      frame(m[0], seed[15:0], RW_WRITE, 15'h0, 2, 8'h0, 1'b1);
      ssh_host_model_inst.stop();
      drain();
      $display("test modes %0d done", m);
    end
    stall <= 1'b1;
    repeat (3) @(posedge clk);
    frame(1'b0, 16'h0100, RW_WRITE, 15'h14, 20, 8'h0, 1'b1);
    `CHK(wr_overflow, 1'b1)
    ssh_host_model_inst.stop();
    `CHK(wr_overflow, 1'b0)
    stall <= 1'b0;
    drain();
    $display("test fifo full done");
    power_down_in <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(low_power, 1'b1)
    frame(1'b0, 16'h0200, RW_WRITE, 15'h2, 2, 8'h0, 1'b0);
    `CHK(miso_oe, 1'b0)
    ssh_host_model_inst.stop();
    power_down_in <= 1'b0;
    repeat (20) @(posedge clk);
    $display("test power down done");
    ign <= 1'b1;
    for (int k = 0; k < N_IRQ; k++) begin
      irq_mask <= ~(4'h1 << k);
      pulse(k);
      `CHK(irq_n, 1'b1)
      irq_mask <= 4'hf;
      pulse(k);
      `CHK(irq_n, 1'b0)
      frame(k[0], k[0] ? 16'h4002 : GLOBAL_IR_ADDR, RW_WRITE, LEN_ONE,
            1, 8'hff, 1'b0);
      ssh_host_model_inst.stop();
      `CHK(irq_n, 1'b1)
    end
    $display("test interrupts done");
    give_verdict();
  end
endmodule : spi_slave_host_port_tb
